// ==== design/rlis_pkg.sv ====
// Package of constants for the receive line input select block.
// Assumes a 100 MHz system clock and a 2048 kHz optical receive clock.
`default_nettype none
package rlis_pkg;
  // ==========================================================
  // Mode encodings
  localparam logic       DIG_SEL_ANALOG  = 1'h0; // Analog line inputs
  localparam logic       DIG_SEL_DIGITAL = 1'h1; // Digital line inputs
  localparam logic       CODE_DUAL_RAIL  = 1'h1; // Dual-rail PCM
  localparam logic       CODE_SINGLE     = 1'h0; // Single-rail optical
  localparam logic [1:0] CODE_PAIR_OPT   = 2'h0; // Optical clock pair value
  // ==========================================================
  // Reset values
  localparam logic       INVERT_RESET    = 1'h1; // Active-low sense after reset
  // ==========================================================
  // Timing
  localparam int CLK_MHZ       = 100;      // System clock rate
  localparam int LINE_KBPS     = 2048;     // Line rate in kbit/s
  // Nominal bit period in system cycles, rounded down (48)
  localparam int BIT_CYCLES    = (CLK_MHZ * 1000) / LINE_KBPS;
  localparam int DPLL_W        = 6;        // Phase counter width
  localparam logic [5:0] BIT_PERIOD = 6'(BIT_CYCLES);
  localparam logic [5:0] BIT_HALF   = 6'(BIT_CYCLES / 2);
endpackage : rlis_pkg
`default_nettype wire

// ==== design/rlis_top.sv ====
// Receive line input selection: analog, dual-rail with DPLL, single-rail optical.
// Assumes rail and optical inputs are asynchronous; optical clock is its own domain.
//
// Overview of operation
// - Select setting 0 takes analog line inputs
// - Select 1, code 1 gives dual-rail mode
// - Dual-rail clock recovered by DPLL, rails sampled
// - Programmable input inversion, active-low after reset
// - Select 1, code 0 gives single-rail optical
// - Optical data latched on falling receive clock
`timescale 1ns/1ps
`default_nettype none
module rlis_top (
  input  wire logic       clk,                 // System clock 100 MHz
  input  wire logic       rst,                 // Async reset, active high
  input  wire logic       line_digital_select, // 0 analog, 1 digital
  input  wire logic [1:0] rx_code_select_pair, // Receive code bits, [1] is hi
  input  wire logic       rx_input_invert_set, // Load pulse for inversion bit
  input  wire logic       rx_input_invert_val, // Value loaded into inversion bit
  input  wire logic       analog_line_rx_a,    // Sliced analog line, positive
  input  wire logic       analog_line_rx_b,    // Sliced analog line, negative
  input  wire logic       rx_rail_positive_in, // Dual-rail positive pulse
  input  wire logic       rx_rail_negative_in, // Dual-rail negative pulse
  input  wire logic       rx_optical_data_in,  // Unipolar optical data
  input  wire logic       rx_optical_clock_in, // Optical receive clock
  input  wire logic       out_ready,           // Downstream ready
  output logic            out_valid,           // Word valid
  output logic [1:0]      out_data,            // {negative mark, positive mark}
  output logic [1:0]      out_mode,            // 0 analog, 1 dual, 2 single
  output logic            rx_input_invert      // Current inversion bit
);
  // ==========================================================
  // Configuration
  // Inversion bit: active-low sense after reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_input_invert <= rlis_pkg::INVERT_RESET;
    end else if (rx_input_invert_set) begin
      rx_input_invert <= rx_input_invert_val;
    end
  end

  wire logic rx_code_select_hi = rx_code_select_pair[1];
  wire logic mode_analog = (line_digital_select == rlis_pkg::DIG_SEL_ANALOG);
  wire logic mode_dual   = !mode_analog
                        && (rx_code_select_hi == rlis_pkg::CODE_DUAL_RAIL);
  wire logic mode_single = !mode_analog
                        && (rx_code_select_hi == rlis_pkg::CODE_SINGLE);

  // ==========================================================
  // Input synchronisers on system clock
  // The inversion bit already runs on this clock and is read directly
  logic [3:0] sync1; // First stage, read only by second stage
  logic [3:0] sync2; // Second stage
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1 <= 4'h0;
      sync2 <= 4'h0;
    end else begin
      sync1 <= {analog_line_rx_b, analog_line_rx_a,
                rx_rail_negative_in, rx_rail_positive_in};
      sync2 <= sync1;
    end
  end

  // Inversion before recovery: marks are active high afterwards
  wire logic rail_p = sync2[0] ^ rx_input_invert;
  wire logic rail_n = sync2[1] ^ rx_input_invert;
  // Marks of the selected source feed bit timing and mark gathering;
  // sliced analog marks are active high and skip the inversion
  wire logic mark_in_p = mode_analog ? sync2[2] : rail_p;
  wire logic mark_in_n = mode_analog ? sync2[3] : rail_n;

  // ==========================================================
  // Digital PLL for dual-rail clock recovery
  logic       rail_any_d;  // Previous mark level
  logic [5:0] phase;       // Bit phase counter
  logic       mark_p;      // Positive mark seen in bit
  logic       mark_n;      // Negative mark seen in bit
  wire logic  rail_any   = mark_in_p | mark_in_n;
  wire logic  rise       = rail_any & ~rail_any_d;
  wire logic  bit_end    = (phase == rlis_pkg::BIT_PERIOD - 6'h01);
  // Realign phase so a mark's leading edge sits at the quarter point
  wire logic [5:0] next_phase = rise ? (rlis_pkg::BIT_HALF >> 1)
                              : (bit_end ? 6'h00 : phase + 6'h01);
  logic       dual_strobe; // Recovered clock tick, one per bit
  logic       ana_d;       // Analog bit tick from the same timing
  logic [1:0] dual_word;   // Marks gathered over one bit
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rail_any_d  <= 1'h0;
      phase       <= 6'h00;
      mark_p      <= 1'h0;
      mark_n      <= 1'h0;
      dual_strobe <= 1'h0;
      ana_d       <= 1'h0;
      dual_word   <= 2'h0;
    end else begin
      rail_any_d  <= rail_any;
      phase       <= next_phase;
      dual_strobe <= bit_end && mode_dual;
      ana_d       <= bit_end && mode_analog;
      if (bit_end) begin
        dual_word <= {mark_n | mark_in_n, mark_p | mark_in_p};
        mark_p    <= 1'h0;
        mark_n    <= 1'h0;
      end else begin
        mark_p <= mark_p | mark_in_p;
        mark_n <= mark_n | mark_in_n;
      end
    end
  end

  // ==========================================================
  // Optical domain: latch on falling receive clock
  logic       opt_bit;     // Latched optical bit, raw sense
  logic       opt_toggle;  // Event toggle per bit
  // Raw bit only; its sense is set on the system clock side
  always_ff @(negedge rx_optical_clock_in or posedge rst) begin
    if (rst) begin
      opt_bit    <= 1'h0;
      opt_toggle <= 1'h0;
    end else begin
      opt_bit    <= rx_optical_data_in;
      opt_toggle <= ~opt_toggle;
    end
  end

  // Bring bit across: toggle plus data held stable for a whole bit
  logic [2:0] tog_sync;  // Toggle sync, [0] first stage
  logic [1:0] bit_sync;  // Data sync
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tog_sync <= 3'h0;
      bit_sync <= 2'h0;
    end else begin
      tog_sync <= {tog_sync[1:0], opt_toggle};
      bit_sync <= {bit_sync[0], opt_bit};
    end
  end
  // Clock expected at 2048 kHz for the optical path
  wire logic opt_strobe = (tog_sync[2] ^ tog_sync[1]) && mode_single;

  // ==========================================================
  // Source selection
  // Optical sense is set here: the receive clock stands still between
  // frames, so a setting carried across on it would only take effect
  // two bits into the next frame
  wire logic  opt_sense = bit_sync[1] ^ rx_input_invert;
  wire logic  src_valid = mode_analog ? ana_d
                        : (mode_dual ? dual_strobe : opt_strobe);
  wire logic [1:0] src_data = mode_single ? {1'h0, opt_sense} : dual_word;
  wire logic [1:0] next_mode = mode_analog ? 2'h0 : (mode_dual ? 2'h1 : 2'h2);

  // ==========================================================
  // Two-entry output buffer
  logic [1:0] buf_mem [2];  // Entries
  logic       wr_ptr;       // Write index
  logic       rd_ptr;       // Read index
  logic [1:0] count;        // Occupancy
  wire logic  push = src_valid && (count != 2'h2);
  wire logic  pop  = out_valid && out_ready;
  wire logic [1:0] next_count = count + {1'h0, push} - {1'h0, pop};
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr     <= 1'h0;
      rd_ptr     <= 1'h0;
      count      <= 2'h0;
      buf_mem[0] <= 2'h0;
      buf_mem[1] <= 2'h0;
    end else begin
      if (push) begin
        buf_mem[wr_ptr] <= src_data;
        wr_ptr          <= ~wr_ptr;
      end
      if (pop) begin
        rd_ptr <= ~rd_ptr;
      end
      count <= next_count;
    end
  end

  // Registered outputs
  wire logic       next_valid = (next_count != 2'h0);
  wire logic       next_rd    = pop ? ~rd_ptr : rd_ptr;
  wire logic [1:0] next_data  = (push && (count == 2'h0 || (pop && count == 2'h1)))
                              ? src_data : buf_mem[next_rd];
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      out_valid <= 1'h0;
      out_data  <= 2'h0;
      out_mode  <= 2'h0;
    end else begin
      out_valid <= next_valid;
      out_data  <= next_data;
      out_mode  <= next_mode;
    end
  end

  // ==========================================================
  // Assertions
  a_reset_invert_high: assert property (@(posedge clk)
    $fell(rst) |-> rx_input_invert) else $error("invert not active low after reset");
  a_dual_mode_code: assert property (@(posedge clk) disable iff (rst)
    dual_strobe |-> $past(line_digital_select && rx_code_select_pair[1]))
    else $error("dual strobe outside dual mode");
  a_dpll_period: assert property (@(posedge clk) disable iff (rst)
    (bit_end && !rise) ##1 !rise [*8] |-> phase == 6'h07) else $error("dpll phase wrong");
  a_analog_select: assert property (@(posedge clk) disable iff (rst)
    !line_digital_select |=> out_mode == 2'h0) else $error("analog not selected");
  a_single_select: assert property (@(posedge clk) disable iff (rst)
    opt_strobe |-> line_digital_select && !rx_code_select_pair[1])
    else $error("optical strobe wrong mode");
  a_buffer_bound: assert property (@(posedge clk) disable iff (rst)
    count != 2'h3) else $error("buffer overflow");
  a_invert_rail: assert property (@(posedge clk) disable iff (rst)
    rail_p == ($past(rx_rail_positive_in, 2) ^ rx_input_invert))
    else $error("rail inversion wrong");
  a_invert_load: assert property (@(posedge clk) disable iff (rst)
    rx_input_invert_set |=> rx_input_invert == $past(rx_input_invert_val))
    else $error("invert bit not loaded");
  a_valid_holds: assert property (@(posedge clk) disable iff (rst)
    out_valid && !out_ready |=> out_valid && $stable(out_data)) else $error("word dropped");
endmodule : rlis_top
`default_nettype wire

// ==== dv/rlis_far_end.sv ====
// Far-end model: optical module and dual-rail line transceiver.
// Assumes the bench calls its tasks by hierarchical name.
`timescale 1ns/1ps
`default_nettype none
module rlis_far_end (
  output logic rail_p, // Positive rail
  output logic rail_n, // Negative rail
  output logic opt_d,  // Optical data
  output logic opt_c   // Optical clock
);
  // ==========================================================
  // Idle: optical clock stands still, rails at space
  initial begin
    {rail_p, rail_n, opt_d, opt_c} = 4'h0;
  end
  // ==========================================================
  // Optical frame, msb first, 80 ns per bit
  task automatic send_opt(input logic [7:0] b, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      opt_d = b[i];
      #20 opt_c = 1'h1;
      #40 opt_c = 1'h0;
      #20;
    end
    opt_d = ~opt_d; // Released line shows the inverse
  endtask : send_opt
  // Half-width marks keep the duty cycle at one half
  task automatic send_rail(input logic [1:0] s);
    {rail_n, rail_p} = s;
    #240 {rail_n, rail_p} = 2'h0;
    #240;
  endtask : send_rail
endmodule : rlis_far_end
`default_nettype wire

// ==== dv/tb_top.sv ====
// Bench for the receive line input select block.
// Assumes the far-end model drives rail, analog and optical pins.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // ==========================================================
  // Stimulus and observed signals
  logic       clk = 1'h0;     // System clock
  logic       rst = 1'h1;     // Reset
  logic       sel = 1'h0;     // Digital select
  logic [1:0] code = 2'h0;    // Code pair
  logic       inv_set = 1'h0; // Inversion load
  logic       inv_val = 1'h0; // Inversion value
  logic       rdy = 1'h1;     // Downstream ready
  wire logic  rp, rn, od, oc; // Far-end pins
  wire logic  vld, inv;       // Valid, inversion bit
  wire logic [1:0] dat, mode; // Word, mode
  logic [1:0] q[$];           // Words taken
  int         fail_count = 0; // Mismatches
  int         tests_run = 0;  // Comparisons
  int         cyc = 0;        // Cycle count
  always #5 clk = ~clk;
  rlis_far_end far (.rail_p(rp), .rail_n(rn), .opt_d(od), .opt_c(oc));
  rlis_top dut (.clk(clk), .rst(rst), .line_digital_select(sel), .rx_code_select_pair(code),
    .rx_input_invert_set(inv_set), .rx_input_invert_val(inv_val), .analog_line_rx_a(rp),
    .analog_line_rx_b(rn), .rx_rail_positive_in(rp), .rx_rail_negative_in(rn),
    .rx_optical_data_in(od), .rx_optical_clock_in(oc), .out_ready(rdy), .out_valid(vld),
    .out_data(dat), .out_mode(mode), .rx_input_invert(inv));
  // Take words and cut a hang short
  always @(posedge clk) begin
    cyc++;
    if (vld === 1'h1 && rdy === 1'h1) q.push_back(dat);
    if (cyc == 20000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  // ==========================================================
  // Tasks
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : tally_and_finish
  // Mode and inversion load, then flush old words
  task automatic setup(input logic s, input logic [1:0] c, input logic i);
    @(posedge clk) #1;
    {sel, code, inv_val, inv_set} = {s, c, i, 1'h1};
    @(posedge clk) #1 inv_set = 1'h0;
    check("invert loaded", {7'h0, inv}, {7'h0, i});
    repeat (150) @(posedge clk);
    q.delete();
  endtask : setup
  task automatic opt_frame(input logic [7:0] b, input logic x);
    @(posedge clk) #1;
    far.send_opt(b, 8);
    repeat (20) @(posedge clk);
    check("word count", 8'(q.size()), 8'h08);
    for (int i = 0; i < 8; i++) check("optical bit", {6'h0, q[i]}, {7'h0, b[7-i] ^ x});
  endtask : opt_frame
  task automatic rail_frame(input logic [1:0] m);
    logic [1:0] pat [4] = '{2'h1, 2'h2, 2'h0, 2'h1};
    int hit;
    hit = 0;
    @(posedge clk) #1;
    for (int k = 0; k < 8; k++) far.send_rail(pat[k % 4]);
    repeat (150) @(posedge clk);
    for (int i = 0; i + 3 < q.size(); i++)
      if (q[i] == pat[0] && q[i+1] == pat[1] && q[i+2] == pat[2] && q[i+3] == pat[3]) hit = 1;
    check("mode", {6'h0, mode}, {6'h0, m});
    check("rail pattern", 8'(hit), 8'h01);
  endtask : rail_frame
  // ==========================================================
  // Main sequence; a stray optical bit early on arrives after single mode is set, and setup flushes its word
  initial begin
    fork
      far.send_opt(8'h00, 1);
    join_none
    repeat (4) @(posedge clk);
    #1 rst = 1'h0;
    check("invert after reset", {7'h0, inv}, 8'h01);
    check("valid after reset", {7'h0, vld}, 8'h00);
    setup(1'h1, 2'h0, 1'h1);
    check("mode", {6'h0, mode}, 8'h02);
    opt_frame(8'hB4, 1'h1);
    setup(1'h1, 2'h0, 1'h0);
    opt_frame(8'h3C, 1'h0);
    // Stall: buffer keeps two words, later bits dropped
    q.delete();
    @(posedge clk) #1 rdy = 1'h0;
    far.send_opt(8'h0A, 4);
    repeat (20) @(posedge clk);
    check("stalled valid", {7'h0, vld}, 8'h01);
    #1 rdy = 1'h1;
    repeat (10) @(posedge clk);
    check("kept words", 8'(q.size()), 8'h02);
    check("first kept", {6'h0, q[0]}, 8'h01);
    check("second kept", {6'h0, q[1]}, 8'h00);
    setup(1'h1, 2'h2, 1'h0);
    rail_frame(2'h1);
    setup(1'h0, 2'h2, 1'h0);
    rail_frame(2'h0);
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
